// File: verilog/rag_regs.vh
/*
 * Constants for the register access mode guard: CPU modes, register
 * classes, address map of the guarded register space, reset values.
 * Assumes an 8-bit register address from the CPU core.
 */
`ifndef RAG_REGS_VH
`define RAG_REGS_VH

// =====================================================================
// CPU modes
`define RAG_MODE_SYSTEM   2'h0
`define RAG_MODE_FIRMWARE 2'h1
`define RAG_MODE_USER     2'h2

// =====================================================================
// Register classes (fixed by address)
`define RAG_CLS_CPU       2'h0
`define RAG_CLS_MMU       2'h1
`define RAG_CLS_HW        2'h2
`define RAG_CLS_NONE      2'h3

// =====================================================================
// Address map of guarded register space
`define RAG_CPU_BASE      8'h00
`define RAG_CPU_LAST      8'h1f
`define RAG_MMU_BASE      8'h20
`define RAG_MMU_LAST      8'h2f
`define RAG_HW_BASE       8'h40
`define RAG_HW_LAST       8'h4f
`define RAG_SEG_PTR_ADDR  8'h20
`define RAG_USR_EN_ADDR   8'h21
`define RAG_FW_EN_ADDR    8'h22
`define RAG_SEG_EN_ADDR   8'h23

// =====================================================================
// Reset values
`define RAG_SEG_PTR_RST   16'h0000
`define RAG_USR_EN_RST    16'h0000
`define RAG_FW_EN_RST     16'h0000
`define RAG_SEG_EN_RST    16'h0000
`define RAG_REG_RST       16'h0000

`endif

// File: verilog/rag_decode.v
/*
 * Address class decoder for the register access mode guard.
 * Assumes the address map from rag_regs.vh; purely combinational.
 */
`include "rag_regs.vh"

module rag_decode (
  input  wire [7:0] i_addr,
  output reg  [1:0] o_cls,
  output reg  [3:0] o_hw_idx
);

  always @* begin
    o_hw_idx = i_addr[3:0];
    if (i_addr <= `RAG_CPU_LAST) begin
      o_cls = `RAG_CLS_CPU;
    end else if (i_addr >= `RAG_MMU_BASE && i_addr <= `RAG_MMU_LAST) begin
      o_cls = `RAG_CLS_MMU;
    end else if (i_addr >= `RAG_HW_BASE && i_addr <= `RAG_HW_LAST) begin
      o_cls = `RAG_CLS_HW;
    end else begin
      o_cls = `RAG_CLS_NONE;
    end
  end

endmodule

// File: verilog/rag_guard.v
/*
 * Register access mode guard: checks each CPU access to the peripheral
 * control registers against the CPU mode, holds the MMU configuration
 * registers and a flop bank for the other guarded registers.
 * Assumes one request per cycle, address and data valid with i_req,
 * and answers one cycle later with o_ack, o_rdata and o_viol.
 */
`include "rag_regs.vh"

module rag_guard #(
  parameter DW = 16
) (
  input  wire          i_clk,
  input  wire          i_srst,
  input  wire [1:0]    i_mode,
  input  wire          i_req,
  input  wire          i_we,
  input  wire [7:0]    i_addr,
  input  wire [DW-1:0] i_wdata,
  output reg           o_ack,
  output reg  [DW-1:0] o_rdata,
  output reg           o_viol,
  output reg  [DW-1:0] o_seg_ptr,
  output reg  [DW-1:0] o_seg_en
);

  // ===================================================================
  // Bank sizes and MMU configuration word codes
  localparam [5:0] CPU_N   = 6'h20;
  localparam [4:0] HW_N    = 5'h10;
  localparam [2:0] MW_NONE = 3'h0;
  localparam [2:0] MW_PTR  = 3'h1;
  localparam [2:0] MW_USR  = 3'h2;
  localparam [2:0] MW_FW   = 3'h3;
  localparam [2:0] MW_SEG  = 3'h4;

  // ===================================================================
  // Storage
  reg  [DW-1:0] seg_ptr_q;
  reg  [DW-1:0] usr_en_q;
  reg  [DW-1:0] fw_en_q;
  reg  [DW-1:0] seg_en_q;
  reg  [DW-1:0] cpu_reg_q [0:CPU_N-1];
  reg  [DW-1:0] hw_reg_q  [0:HW_N-1];
  wire [1:0]    cls;
  wire [3:0]    hw_idx;
  reg           allow_d;
  reg  [DW-1:0] rd_d;
  wire [2:0]    mmu_sel;
  wire          rd_ok;
  wire          wr_ok;
  wire          wr_mmu;
  wire          wr_cpu;
  wire          wr_hw;

  rag_decode u_dec (
    .i_addr   (i_addr),
    .o_cls    (cls),
    .o_hw_idx (hw_idx)
  );

  // ===================================================================
  // MMU configuration word decode, shared by the read mux and the writes
  function [2:0] mmu_word;
    input [7:0] addr;
    begin
      case (addr)
        `RAG_SEG_PTR_ADDR: mmu_word = MW_PTR;
        `RAG_USR_EN_ADDR:  mmu_word = MW_USR;
        `RAG_FW_EN_ADDR:   mmu_word = MW_FW;
        `RAG_SEG_EN_ADDR:  mmu_word = MW_SEG;
        default:           mmu_word = MW_NONE;
      endcase
    end
  endfunction

  // ===================================================================
  // Access decision
  always @* begin
    allow_d = 1'b0;
    case (cls)
      `RAG_CLS_CPU: begin
        allow_d = 1'b1;
      end
      `RAG_CLS_MMU: begin
        allow_d = (i_mode == `RAG_MODE_SYSTEM);
      end
      `RAG_CLS_HW: begin
        // Mode 3 is undefined and gets no hardware register rights
        case (i_mode)
          `RAG_MODE_SYSTEM: begin
            allow_d = 1'b1;
          end
          `RAG_MODE_USER: begin
            allow_d = usr_en_q[hw_idx];
          end
          `RAG_MODE_FIRMWARE: begin
            allow_d = fw_en_q[hw_idx];
          end
          default: begin
            allow_d = 1'b0;
          end
        endcase
      end
      default: allow_d = 1'b0;
    endcase
  end

  // ===================================================================
  // Access strobes
  assign mmu_sel = mmu_word(i_addr);
  assign rd_ok   = i_req && !i_we && allow_d;
  assign wr_ok   = i_req && i_we && allow_d;
  assign wr_mmu  = wr_ok && (cls == `RAG_CLS_MMU);
  assign wr_cpu  = wr_ok && (cls == `RAG_CLS_CPU);
  assign wr_hw   = wr_ok && (cls == `RAG_CLS_HW);

  // Read mux: in the MMU range only 0x20..0x23 hold data, other MMU and unmapped addresses read zero
  always @* begin
    rd_d = {DW{1'b0}};
    case (cls)
      `RAG_CLS_CPU: rd_d = cpu_reg_q[i_addr[4:0]];
      `RAG_CLS_HW:  rd_d = hw_reg_q[hw_idx];
      `RAG_CLS_MMU: begin
        case (mmu_sel)
          MW_PTR:  rd_d = seg_ptr_q;
          MW_USR:  rd_d = usr_en_q;
          MW_FW:   rd_d = fw_en_q;
          MW_SEG:  rd_d = seg_en_q;
          default: rd_d = {DW{1'b0}};
        endcase
      end
      default: rd_d = {DW{1'b0}};
    endcase
  end

  // ===================================================================
  // MMU configuration registers
  always @(posedge i_clk) begin
    if (i_srst) begin
      seg_ptr_q <= `RAG_SEG_PTR_RST;
      usr_en_q  <= `RAG_USR_EN_RST;
      fw_en_q   <= `RAG_FW_EN_RST;
      seg_en_q  <= `RAG_SEG_EN_RST;
    end else if (wr_mmu) begin
      case (mmu_sel)
        MW_PTR: begin
          seg_ptr_q <= i_wdata;
        end
        MW_USR: begin
          usr_en_q  <= i_wdata;
        end
        MW_FW: begin
          fw_en_q   <= i_wdata;
        end
        MW_SEG: begin
          seg_en_q  <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ===================================================================
  // CPU and hardware register banks
  genvar gi;
  generate
    for (gi = 0; gi < CPU_N; gi = gi + 1) begin : g_cpu
      always @(posedge i_clk) begin
        if (i_srst) begin
          cpu_reg_q[gi] <= `RAG_REG_RST;
        end else if (wr_cpu && i_addr[4:0] == gi) begin
          cpu_reg_q[gi] <= i_wdata;
        end
      end
    end
    for (gi = 0; gi < HW_N; gi = gi + 1) begin : g_hw
      always @(posedge i_clk) begin
        if (i_srst) begin
          hw_reg_q[gi] <= `RAG_REG_RST;
        end else if (wr_hw && hw_idx == gi) begin
          hw_reg_q[gi] <= i_wdata;
        end
      end
    end
  endgenerate

  // ===================================================================
  // Answer
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_ack     <= 1'b0;
      o_rdata   <= {DW{1'b0}};
      o_viol    <= 1'b0;
    end else begin
      o_ack     <= i_req;
      o_viol    <= i_req && !allow_d;
      o_rdata   <= rd_ok ? rd_d : {DW{1'b0}};
    end
  end

  // ===================================================================
  // Segment mirrors, one cycle behind the live registers
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_seg_ptr <= `RAG_SEG_PTR_RST;
      o_seg_en  <= `RAG_SEG_EN_RST;
    end else begin
      o_seg_ptr <= seg_ptr_q;
      o_seg_en  <= seg_en_q;
    end
  end

endmodule

// File: bench/rag_cpu_model.sv
/* Behavioural CPU core issuing guarded register accesses.
   Assumes each request is taken on the rising edge of i_clk. */
module rag_cpu_model (
  input  logic        i_clk,
  output logic [1:0]  o_mode,
  output logic        o_req,
  output logic        o_we,
  output logic [7:0]  o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_mode, o_req, o_we, o_addr, o_wdata} = '0;
  end
  // One access; released lines show the inverse of their last value
  task go(input logic [1:0] m, input logic w, input logic [7:0] a,
          input logic [15:0] d);
    @(posedge i_clk);
    {o_mode, o_req, o_we, o_addr, o_wdata} <= {m, 1'b1, w, a, d};
    @(posedge i_clk);
    {o_req, o_addr, o_wdata} <= {1'b0, ~a, ~d};
  endtask
endmodule

// File: bench/rag_guard_monitor.sv
/* Checker on the guard ports.
   Assumes one clock and a synchronous active-high reset. */
module rag_guard_monitor (
  input logic        i_clk,
  input logic        i_srst,
  input logic [1:0]  i_mode,
  input logic        i_req,
  input logic        i_we,
  input logic [7:0]  i_addr,
  input logic [15:0] i_wdata,
  input logic        o_ack,
  input logic [15:0] o_rdata,
  input logic        o_viol,
  input logic [15:0] o_seg_ptr,
  input logic [15:0] o_seg_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire sys = i_mode == 2'h0;
  wire mmu = i_req && i_addr[7:4] == 4'h2;
  wire ptw = mmu && i_we && i_addr[3:0] == 4'h0;
  property p_mmu; mmu && !sys |=> o_viol; endproperty
  a_mmu: assert property (p_mmu) else $error("mmu open");
  property p_ptr;
    ptw && sys |-> ##2 o_seg_ptr == $past(i_wdata, 2);
  endproperty
  a_ptr: assert property (p_ptr) else $error("ptr lost");
  property p_keep; ptw && !sys |-> ##2 $stable(o_seg_ptr); endproperty
  a_keep: assert property (p_keep) else $error("ptr moved");
  property p_hw; i_req && sys && i_addr[7:4] == 4'h4 |=> !o_viol; endproperty
  a_hw: assert property (p_hw) else $error("hw shut");
  property p_cpu; i_req && i_addr[7:5] == 3'h0 |=> !o_viol; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu shut");
  property p_gap; i_req && i_addr[7:4] == 4'h3 |=> o_viol; endproperty
  a_gap: assert property (p_gap) else $error("gap open");
  property p_den; o_viol |-> o_ack && o_rdata == 16'h0000; endproperty
  a_den: assert property (p_den) else $error("leak");
  property p_rst; $fell(i_srst) |-> !o_ack && o_seg_en == 16'h0000
    && o_seg_ptr == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("dirty reset");
  c_ptw: cover property (ptw && sys);
  c_den: cover property (mmu && !sys);
  c_viol: cover property (o_viol);
  c_fwhw: cover property (i_req && i_mode == 2'h1 && i_addr[7:4] == 4'h4
    ##1 !o_viol);
endmodule
bind rag_guard rag_guard_monitor u_mon (.i_clk(i_clk), .i_srst(i_srst),
  .i_mode(i_mode), .i_req(i_req), .i_we(i_we), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata), .o_viol(o_viol),
  .o_seg_ptr(o_seg_ptr), .o_seg_en(o_seg_en));

// File: bench/test_rag_guard.sv
/* Self-checking bench for the register access mode guard.
   Assumes the CPU model drives every request input. */
`define CK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_rag_guard;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk, i_srst, req, we, ack, viol;
  logic [1:0]  mode;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, ptr, segen;
  int          fails, check_count;
  // =====================================================================
  // Rows: mode, we, addr, wdata, expected viol, expected rdata
  logic [51:0] rows [16] = '{
    52'h0_1_20_1234_0_0000, 52'h0_0_20_0000_0_1234,
    52'h2_1_20_5555_1_0000, 52'h2_0_20_0000_1_0000,
    52'h0_0_20_0000_0_1234, 52'h1_0_21_0000_1_0000,
    52'h2_1_40_aaaa_1_0000, 52'h0_1_40_aaaa_0_0000,
    52'h0_1_21_0001_0_0000, 52'h2_0_40_0000_0_aaaa,
    52'h1_1_40_1111_1_0000, 52'h2_1_05_0077_0_0000,
    52'h2_0_05_0000_0_0077, 52'h0_0_30_0000_1_0000,
    52'h0_1_23_00ff_0_0000, 52'h3_0_40_0000_1_0000};
  rag_cpu_model u_cpu (.i_clk(i_clk), .o_mode(mode), .o_req(req),
    .o_we(we), .o_addr(addr), .o_wdata(wdata));
  rag_guard u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_mode(mode),
    .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_ack(ack),
    .o_rdata(rdata), .o_viol(viol), .o_seg_ptr(ptr), .o_seg_en(segen));
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task acc(input logic [51:0] r);
    int n;
    u_cpu.go(r[49:48], r[44], r[43:36], r[35:20]);
    #1;
    for (n = 0; n < 4 && ack !== 1'b1; n++) @(posedge i_clk) #1;
    if (n == 4) begin
      fails++;
      report_and_stop;
    end
    `CK(viol, r[16])
    `CK(rdata, r[15:0])
    @(posedge i_clk) #1;
    `CK(ack, 1'b0)
    `CK(viol, 1'b0)
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    i_srst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (rows[i]) acc(rows[i]);
    acc(52'h0_0_40_0000_0_aaaa);
    acc(52'h0_1_41_3c3c_0_0000);
    acc(52'h0_1_22_0002_0_0000);
    acc(52'h1_0_41_0000_0_3c3c);
    acc(52'h1_0_40_0000_1_0000);
    acc(52'h2_0_41_0000_1_0000);
    `CK(ptr, 16'h1234)
    `CK(segen, 16'h00ff)
    $display("table test done");
    @(posedge i_clk);
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    `CK(ptr, 16'h0000)
    `CK(segen, 16'h0000)
    acc(52'h2_0_40_0000_1_0000);
    acc(52'h1_0_41_0000_1_0000);
    acc(52'h0_0_41_0000_0_0000);
    acc(52'h0_0_20_0000_0_0000);
    $display("reset test done");
    report_and_stop;
  end
endmodule
